// ### bench/sees_bus_master.sv
`timescale 1ns/100ps

// Two-wire bus master: owns the bus clock, pulls the data line low or releases it
module sees_bus_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    // Bus idles with clock high and data released
    initial
    begin
        scl_o  = 1'b1;
        pull_o = 1'b0;
    end

    // Wait a number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Release data while clock low, then data falls while clock high
    task automatic start();
        tick(1);
        pull_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        pull_o <= 1'b1;
        tick(3);
        scl_o <= 1'b0;
    endtask

    // Data rises while clock high; clock then stands still high
    task automatic stop();
        tick(1);
        pull_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        pull_o <= 1'b0;
        tick(4);
    endtask

    // One slot: data set while clock low, held and sampled while clock high
    task automatic clock_bit(input logic drive, output logic seen);
        tick(1);
        pull_o <= ~drive;
        tick(5);
        scl_o <= 1'b1;
        tick(2);
        seen = sda_i;
        scl_o <= 1'b0;
    endtask

    // Eight bits MSB first, then a released ack slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask

    // Eight bits in, then ack to ask for more or release to end
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clock_bit(1'b1, s);
            b[i] = s;
        end
        clock_bit(~more, s);
    endtask
endmodule

// ### bench/test_sees_eeprom.sv
`timescale 1ns/100ps

`define CHECK(name, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected %s: expected %0h seen %0h", name, exp, got); \
        end \
    end

module test_sees_eeprom;
    localparam int PROG = 400;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        wp_i        = 1'b0;
    logic [31:0] page_lock_i = 32'h00000000;
    logic        scl;
    logic        pull;
    logic        sda_o;
    logic        sda_oe_o;
    logic        prog_busy_o;
    logic [7:0]  mem [256];
    int          miscompares;
    int          samples_checked;
    int          busy_len = 0;
    int          busy_max = 0;
    // Open-drain data line with pull-up
    wire         sda = ~(pull | (sda_oe_o & ~sda_o));

    always #50 clk_i = ~clk_i;

    // Length of each programming cycle in system clocks, and the longest seen
    always @(posedge clk_i)
    begin
        busy_len <= prog_busy_o ? busy_len + 1 : 0;
        if (busy_len > busy_max)
            busy_max <= busy_len;
    end

    sees_eeprom #(.PROG_CYCLES(PROG)) sees_eeprom_i (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .wp_i(wp_i), .page_lock_i(page_lock_i),
        .prog_busy_o(prog_busy_o));

    sees_bus_master sees_bus_master_i (
        .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));

    // Print counts and verdict, then end the run
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Write command, address and n data bytes; model updated when programming is due
    task automatic write_seq(input logic [7:0] a, input logic [63:0] d, input int n,
                             input logic prog);
        logic ack;
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hA0, ack);
        `CHECK("command ack", 1'b1, ack)
        sees_bus_master_i.send_byte(a, ack);
        `CHECK("address ack", 1'b1, ack)
        for (int i = 0; i < n; i++)
        begin
            sees_bus_master_i.send_byte(d[8*i +: 8], ack);
            `CHECK("data ack", 1'b1, ack)
            if (prog)
                mem[{a[7:3], 3'(a[2:0] + i)}] = d[8*i +: 8];
        end
        sees_bus_master_i.stop();
    endtask

    // Random read of n bytes, master acks all but the last
    task automatic read_seq(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] b;
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hA0, ack);
        sees_bus_master_i.send_byte(a, ack);
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hA1, ack);
        `CHECK("read command ack", 1'b1, ack)
        for (int i = 0; i < n; i++)
        begin
            sees_bus_master_i.recv_byte(i < n - 1, b);
            `CHECK("read data", mem[8'(a + i)], b)
        end
        `CHECK("drive level", 1'b0, sda_o)
        sees_bus_master_i.stop();
    endtask

    // Watch for programming, optionally poll while busy, wait for the end
    task automatic settle(input logic exp, input logic poll);
        logic seen;
        logic ack;
        int   n;
        seen = 1'b0;
        repeat (10)
        begin
            @(posedge clk_i);
            seen = seen | prog_busy_o;
        end
        `CHECK("programming started", exp, seen)
        if (poll)
        begin
            sees_bus_master_i.start();
            sees_bus_master_i.send_byte(8'hA0, ack);
            `CHECK("busy poll ack", 1'b0, ack)
            sees_bus_master_i.stop();
        end
        n = 0;
        while (prog_busy_o !== 1'b0 && n <= PROG)
        begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        `CHECK("programming bounded", 1'b1, (n <= PROG) && (busy_max <= PROG))
        if (n > PROG)
            give_verdict();
    endtask

    // Outputs quiet after reset
    task automatic s_reset();
        `CHECK("data drive after reset", 1'b0, sda_oe_o)
        `CHECK("busy after reset", 1'b0, prog_busy_o)
    endtask

    // Wrong pattern refused; don't-care bits ignored
    task automatic s_command();
        logic ack;
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'h50, ack);
        `CHECK("foreign command ack", 1'b0, ack)
        sees_bus_master_i.stop();
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hAE, ack);
        `CHECK("don't-care command ack", 1'b1, ack)
        sees_bus_master_i.stop();
        settle(1'b0, 1'b0);
    endtask

    // Two byte writes to one place, poll, then current address read
    task automatic s_byte_write();
        logic       ack;
        logic [7:0] b;
        write_seq(8'h12, 64'h5A, 1, 1'b1);
        settle(1'b1, 1'b1);
        write_seq(8'h12, 64'hA5, 1, 1'b1);
        settle(1'b1, 1'b0);
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hA0, ack);
        `CHECK("poll ack when idle", 1'b1, ack)
        sees_bus_master_i.start();
        sees_bus_master_i.send_byte(8'hA1, ack);
        sees_bus_master_i.recv_byte(1'b0, b);
        `CHECK("counter after programming", 8'hA5, b)
        sees_bus_master_i.stop();
    endtask

    // Five bytes from near the page end wrap inside the page
    task automatic s_page_write();
        write_seq(8'h1D, 64'h0504030201, 5, 1'b1);
        settle(1'b1, 1'b0);
        read_seq(8'h18, 8);
        settle(1'b0, 1'b0);
    endtask

    // Write-protect pin and page lock both suppress programming
    task automatic s_protect();
        wp_i <= 1'b1;
        write_seq(8'h40, 64'h11, 1, 1'b0);
        settle(1'b0, 1'b0);
        wp_i        <= 1'b0;
        page_lock_i <= 32'h00000200;
        write_seq(8'h48, 64'h22, 2, 1'b0);
        settle(1'b0, 1'b0);
        page_lock_i <= 32'h00000000;
        read_seq(8'h40, 1);
        read_seq(8'h48, 2);
    endtask

    // Main sequence
    initial
    begin
        miscompares     = 0;
        samples_checked = 0;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'hFF;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        s_reset();
        s_command();
        s_byte_write();
        s_page_write();
        s_protect();
        give_verdict();
    end
endmodule

// ### hdl/sees_defs.svh
`ifndef SEES_DEFS_SVH
`define SEES_DEFS_SVH

// Bus framing
`define SEES_CMD_PATTERN   4'hA
`define SEES_BITS_LAST     4'h8
`define SEES_BIT_ACK       4'h9
`define SEES_BIT_ZERO      4'h0
`define SEES_BIT_ONE       4'h1

// Array geometry
`define SEES_ADDR_MASK     8'hFF
`define SEES_ADDR_ZERO     8'h00
`define SEES_ADDR_STEP     8'h01
`define SEES_LOW_STEP      3'h1
`define SEES_MASK_NONE     8'h00
`define SEES_ERASED        8'hFF
`define SEES_PAGE_COUNT    32

// Timing
`define SEES_CLK_MHZ       10
`define SEES_PROG_TIME_US  8000
`define SEES_PROG_STEPS    3
`define SEES_TMR_ZERO      17'h00000
`define SEES_TMR_STEP      17'h00001

// Write data buffering
`define SEES_FIFO_DEPTH    4

`endif

// ### hdl/sees_eeprom.sv
`timescale 1ns/100ps
`include "sees_defs.svh"

// Small flop FIFO with valid/ready on both sides
module sees_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshake decode
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage and pointers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Functional notes
// - Sample data on clock rise, change driven data on clock fall.
// - Data line is only pulled low or released, never driven high.
// - Write-protect high blocks every change to the array. Sampled only at the STOP that starts programming; a running cycle completes.
// - Data fall with clock high is START; data rise with clock high is STOP.
// - STOP after write data starts programming; STOP after read returns to idle.
// - Receiver pulls data low in ninth clock; transmitter releases it then.
// - Data changes only while clock low; nine clocks per byte, MSB first.
// - First byte is command: 1010 in bits 7-4, bit 0 selects read.
// - Byte after write command is loaded into address counter and acked.
// - Counter advances after each acked write byte and each byte read.
// - Byte write acks command, address, data; data goes to buffer.
// - Programming erases selected bytes to ones, then writes buffer.
// - Erase-and-write finishes within 8 ms.
// - Page write takes one to eight data bytes into page buffer.
// - During page entry only low three address bits increment.
// - Unaddressed bytes of the page stay untouched.
// - No command is acked while programming runs.
// - After programming, counter holds last entered data byte address.
// - Repeated START after address aborts write; read command then acked.
// - After read command ack, shift out byte at counter and advance it.
// - Programming aimed at a locked page is suppressed.
module sees_eeprom #(
    parameter int PROG_CYCLES = `SEES_PROG_TIME_US * `SEES_CLK_MHZ
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        wp_i,
    input  wire logic [31:0] page_lock_i,
    output logic             prog_busy_o
);
    localparam logic [16:0] TMR_LAST = 17'(PROG_CYCLES) - `SEES_TMR_STEP;

    logic                  scl_s1, scl_s2, scl_q;
    logic                  sda_s1, sda_s2, sda_q;
    logic                  wp_s1, wp_s2;
    sees_pkg::sees_phase_t ph_q;
    sees_pkg::sees_eng_t   eng_q;
    logic [3:0]            bit_q;
    logic [7:0]            sh_q;
    logic [7:0]            tx_q;
    logic                  oe_q;
    logic                  mack_q;
    logic                  got_data_q;
    logic [7:0]            addr_q;
    logic [7:0]            last_q;
    logic [4:0]            page_q;
    logic [7:0]            buf_q [8];
    logic [7:0]            mask_q;
    logic [16:0]           tmr_q;
    logic [7:0]            mem_q [256];
    logic                  scl_rise, scl_fall, start_ev, stop_ev;
    logic                  byte_end, ack_end, cmd_ok, busy;
    logic                  wr_ack, prog_go, prog_done, rd_load;
    sees_pkg::sees_wr_t    wr_in, wr_out;
    logic                  fifo_rdy, fifo_vld, fifo_pop;

    // Pin synchronisers, then one more stage for edge finding
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {scl_s1, scl_s2, scl_q} <= 3'h7;
            {sda_s1, sda_s2, sda_q} <= 3'h7;
            {wp_s1, wp_s2}          <= 2'h0;
        end
        else
        begin
            {scl_s1, scl_s2, scl_q} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_q} <= {sda_i, sda_s1, sda_s2};
            {wp_s1, wp_s2}          <= {wp_i, wp_s1};
        end
    end

    // Bus event decode
    assign scl_rise  = scl_s2 && !scl_q;
    assign scl_fall  = !scl_s2 && scl_q;
    assign start_ev  = scl_s2 && scl_q && sda_q && !sda_s2;
    assign stop_ev   = scl_s2 && scl_q && !sda_q && sda_s2;
    assign byte_end  = scl_fall && (bit_q == `SEES_BITS_LAST) && (ph_q != sees_pkg::PH_IDLE);
    assign ack_end   = scl_fall && (bit_q == `SEES_BIT_ACK);
    assign busy      = (eng_q != sees_pkg::EN_IDLE);
    assign cmd_ok    = (sh_q[7:4] == `SEES_CMD_PATTERN) && !busy;
    assign wr_ack    = byte_end && (ph_q == sees_pkg::PH_WDATA) && fifo_rdy;
    assign wr_in     = '{idx: addr_q[2:0], data: sh_q};
    // Low data line in a read ack slot (own command ack or master ack) fetches a byte
    assign rd_load   = scl_rise && (bit_q == `SEES_BIT_ACK)
                       && (ph_q == sees_pkg::PH_RDATA) && !sda_s2;
    assign prog_go   = stop_ev && (ph_q == sees_pkg::PH_WDATA) && got_data_q
                       && !wp_s2;
    assign sda_o     = 1'b0;
    assign sda_oe_o  = oe_q;
    assign prog_busy_o = busy;

    // Bit counter and shift-in on clock rise
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_ev || stop_ev)
        begin
            bit_q  <= `SEES_BIT_ZERO;
            sh_q   <= `SEES_ADDR_ZERO;
            mack_q <= 1'b1;
        end
        else if (scl_rise && (bit_q == `SEES_BIT_ACK))
            mack_q <= sda_s2;
        else if (scl_rise && (bit_q < `SEES_BITS_LAST))
        begin
            sh_q  <= {sh_q[6:0], sda_s2};
            bit_q <= bit_q + `SEES_BIT_ONE;
        end
        else if (byte_end)
            bit_q <= `SEES_BIT_ACK;
        else if (ack_end)
            bit_q <= `SEES_BIT_ZERO;
    end

    // Transfer phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i || stop_ev)
            ph_q <= sees_pkg::PH_IDLE;
        else if (start_ev)
            ph_q <= sees_pkg::PH_CMD;
        else if (byte_end)
        begin
            unique case (ph_q)
                sees_pkg::PH_CMD:
                    ph_q <= !cmd_ok ? sees_pkg::PH_IDLE :
                            sh_q[0] ? sees_pkg::PH_RDATA : sees_pkg::PH_ADDR;
                sees_pkg::PH_ADDR:  ph_q <= sees_pkg::PH_WDATA;
                sees_pkg::PH_WDATA: ph_q <= sees_pkg::PH_WDATA;
                sees_pkg::PH_RDATA: ph_q <= sees_pkg::PH_RDATA;
                sees_pkg::PH_IDLE:  ph_q <= sees_pkg::PH_IDLE;
            endcase
        end
        else if (ack_end && (ph_q == sees_pkg::PH_RDATA) && mack_q)
            ph_q <= sees_pkg::PH_IDLE;
    end

    // Data line drive, changed on clock fall; cleared by reset, START or STOP
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_ev || stop_ev)
            oe_q <= 1'b0;
        else if (byte_end)
        begin
            unique case (ph_q)
                sees_pkg::PH_CMD:   oe_q <= cmd_ok;
                sees_pkg::PH_ADDR:  oe_q <= 1'b1;
                sees_pkg::PH_WDATA: oe_q <= fifo_rdy;
                sees_pkg::PH_RDATA: oe_q <= 1'b0;
                sees_pkg::PH_IDLE:  oe_q <= 1'b0;
            endcase
        end
        else if (ack_end)
            oe_q <= (ph_q == sees_pkg::PH_RDATA) && !mack_q && !tx_q[7];
        else if (scl_fall && (ph_q == sees_pkg::PH_RDATA) && (bit_q != `SEES_BIT_ZERO))
            oe_q <= !tx_q[6];
    end

    // Read shift register, loaded at the ack slot
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_q <= `SEES_ERASED;
        else if (rd_load)
            tx_q <= mem_q[addr_q];
        else if (scl_fall && (ph_q == sees_pkg::PH_RDATA) && (bit_q < `SEES_BITS_LAST))
            tx_q <= {tx_q[6:0], 1'b1};
    end

    // Address counter, page base and last entered byte
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_q <= `SEES_ADDR_ZERO;
            last_q <= `SEES_ADDR_ZERO;
            page_q <= '0;
        end
        else if (byte_end && (ph_q == sees_pkg::PH_ADDR))
        begin
            addr_q <= sh_q & `SEES_ADDR_MASK;
            page_q <= sh_q[7:3];
        end
        else if (wr_ack)
        begin
            last_q <= addr_q;
            addr_q <= {addr_q[7:3], addr_q[2:0] + `SEES_LOW_STEP};
        end
        else if (rd_load)
            addr_q <= addr_q + `SEES_ADDR_STEP;
        else if (prog_done)
            addr_q <= last_q;
    end

    // Data-byte bookkeeping; a repeated START drops a pending write
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_ev || stop_ev)
            got_data_q <= 1'b0;
        else if (wr_ack)
            got_data_q <= 1'b1;
    end

    // Received write bytes queue toward the page buffer
    sees_fifo #(
        .WIDTH ($bits(sees_pkg::sees_wr_t)),
        .DEPTH (`SEES_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (wr_in),
        .in_valid_i  (wr_ack),
        .in_ready_o  (fifo_rdy),
        .out_data_o  (wr_out),
        .out_valid_o (fifo_vld),
        .out_ready_i (fifo_pop)
    );
    assign fifo_pop = fifo_vld && ((eng_q == sees_pkg::EN_IDLE) ||
                                   (eng_q == sees_pkg::EN_DRAIN));

    // Page buffer with per-byte selection mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_q <= `SEES_MASK_NONE;
        else if (fifo_pop)
        begin
            buf_q[wr_out.idx]  <= wr_out.data;
            mask_q[wr_out.idx] <= 1'b1;
        end
        else if (start_ev && (eng_q == sees_pkg::EN_IDLE))
            mask_q <= `SEES_MASK_NONE;
        else if (prog_done)
            mask_q <= `SEES_MASK_NONE;
    end

    // Programming engine: drain, erase, write, timed wait
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            eng_q <= sees_pkg::EN_IDLE;
        else
        begin
            unique case (eng_q)
                sees_pkg::EN_IDLE:
                    if (prog_go && !page_lock_i[page_q])
                        eng_q <= sees_pkg::EN_DRAIN;
                sees_pkg::EN_DRAIN:
                    if (!fifo_vld)
                        eng_q <= sees_pkg::EN_ERASE;
                sees_pkg::EN_ERASE: eng_q <= sees_pkg::EN_WRITE;
                sees_pkg::EN_WRITE: eng_q <= sees_pkg::EN_WAIT;
                sees_pkg::EN_WAIT:
                    if (tmr_q == TMR_LAST)
                        eng_q <= sees_pkg::EN_IDLE;
            endcase
        end
    end

    // Cycle timer over the whole busy time, so busy never outlasts PROG_CYCLES
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (eng_q == sees_pkg::EN_IDLE))
            tmr_q <= `SEES_TMR_ZERO;
        else
            tmr_q <= tmr_q + `SEES_TMR_STEP;
    end
    assign prog_done = (eng_q == sees_pkg::EN_WAIT) && (tmr_q == TMR_LAST);

    // Array bytes, each touched only when selected in the page
    for (genvar gi = 0; gi < 256; gi++)
    begin : g_cell
        logic sel;
        assign sel = (page_q == 5'(gi / 8)) && mask_q[gi % 8];
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                mem_q[gi] <= `SEES_ERASED;
            else if (sel && (eng_q == sees_pkg::EN_ERASE))
                mem_q[gi] <= `SEES_ERASED;
            else if (sel && (eng_q == sees_pkg::EN_WRITE))
                mem_q[gi] <= buf_q[gi % 8];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_drive_on_fall;
        $rose(oe_q) |-> $past(scl_fall);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive rose off fall");

    property p_cmd_ack;
        (byte_end && ph_q == sees_pkg::PH_CMD && cmd_ok) |=> oe_q && bit_q == `SEES_BIT_ACK;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("command not acked");

    property p_busy_nack;
        (byte_end && ph_q == sees_pkg::PH_CMD && busy) |=> !oe_q ##1 !oe_q;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

    property p_wp_blocks;
        (eng_q == sees_pkg::EN_IDLE && wp_s2) |=> eng_q == sees_pkg::EN_IDLE;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("program under protect");

    property p_erase_write;
        eng_q == sees_pkg::EN_ERASE |=> eng_q == sees_pkg::EN_WRITE ##1 eng_q == sees_pkg::EN_WAIT;
    endproperty
    a_erase_write: assert property (p_erase_write) else $error("bad program order");

    property p_prog_len;
        busy |-> tmr_q <= TMR_LAST;
    endproperty
    a_prog_len: assert property (p_prog_len) else $error("program overran");

    property p_addr_load;
        (byte_end && ph_q == sees_pkg::PH_ADDR) |=> addr_q == $past(sh_q) && ph_q == sees_pkg::PH_WDATA;
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded");

    property p_page_fixed;
        wr_ack |=> addr_q[7:3] == $past(addr_q[7:3]) && addr_q[2:0] == $past(addr_q[2:0]) + 3'h1;
    endproperty
    a_page_fixed: assert property (p_page_fixed) else $error("page bits moved");

    property p_start;
        start_ev |=> ph_q == sees_pkg::PH_CMD && bit_q == `SEES_BIT_ZERO && !oe_q;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_done_addr;
        prog_done |=> addr_q == $past(last_q) && eng_q == sees_pkg::EN_IDLE;
    endproperty
    a_done_addr: assert property (p_done_addr) else $error("counter not restored");
endmodule

// ### hdl/sees_pkg.sv
package sees_pkg;

    // Bus-side transfer phase
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CMD,
        PH_ADDR,
        PH_WDATA,
        PH_RDATA
    } sees_phase_t;

    // Programming engine state
    typedef enum logic [2:0] {
        EN_IDLE,
        EN_DRAIN,
        EN_ERASE,
        EN_WRITE,
        EN_WAIT
    } sees_eng_t;

    // One received write byte and its slot within the page
    typedef struct packed {
        logic [2:0] idx;
        logic [7:0] data;
    } sees_wr_t;

endpackage
